/* include/dwt_pkg.sv */
// constants and types for the write-training fifo and dqs oscillator
`default_nettype none

package dwt_pkg;

  // ----------------------------------------------------------------
  // fifo geometry
  // ----------------------------------------------------------------
  localparam int unsigned FIFO_ENTRIES = 5;
  localparam int unsigned BURST_BEATS  = 16;
  localparam int unsigned DQ_W         = 16;
  localparam int unsigned FIFO_WORDS   = FIFO_ENTRIES * BURST_BEATS;
  localparam logic [2:0]  ENTRY_FIRST  = 3'h0;
  localparam logic [2:0]  ENTRY_LAST   = 3'h4;
  localparam logic [3:0]  BEAT_FIRST   = 4'h0;
  localparam logic [3:0]  BEAT_LAST    = 4'hf;
  localparam logic [15:0] UNDEF_FILL   = 16'h0000;

  // ----------------------------------------------------------------
  // command codes
  // ----------------------------------------------------------------
  localparam logic [4:0] CMD_MPC  = 5'h00;
  localparam logic [4:0] CMD_WR   = 5'h04;
  localparam logic [4:0] CMD_MWR  = 5'h0c;
  localparam logic [4:0] CMD_RD   = 5'h02;
  localparam logic [4:0] CMD_MRR  = 5'h0e;
  localparam logic [4:0] CMD_CAS2 = 5'h12;
  localparam int unsigned OP6_BIT = 5;
  localparam logic [5:0] MPC_RD_FIFO   = 6'h01;
  localparam logic [5:0] MPC_RD_CAL    = 6'h03;
  localparam logic [5:0] MPC_WR_FIFO   = 6'h07;
  localparam logic [5:0] MPC_OSC_START = 6'h0b;
  localparam logic [5:0] MPC_OSC_STOP  = 6'h0d;

  // ----------------------------------------------------------------
  // oscillator
  // ----------------------------------------------------------------
  localparam logic [15:0] OSC_MAX         = 16'hffff;
  localparam int unsigned OSC_MIN_RUN_NS  = 200;
  localparam int unsigned CORE_PERIOD_NS  = 40;
  localparam logic [15:0] OSC_MIN_RUN_CYC = 16'((OSC_MIN_RUN_NS + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS);

  // ----------------------------------------------------------------
  // register map and reset values
  // ----------------------------------------------------------------
  localparam logic [2:0]  ADDR_OSC_LOW  = 3'h0;
  localparam logic [2:0]  ADDR_OSC_HIGH = 3'h1;
  localparam logic [2:0]  ADDR_CTRL     = 3'h2;
  localparam logic [2:0]  ADDR_RUNLEN   = 3'h3;
  localparam logic [2:0]  ADDR_LAT      = 3'h4;
  localparam logic [2:0]  ADDR_STATUS   = 3'h5;
  localparam int unsigned CTRL_AUTO_BIT = 0;
  localparam logic [15:0] RUNLEN_RESET  = 16'h0040;
  localparam logic [5:0]  WL_RESET      = 6'h06;
  localparam logic [5:0]  RL_RESET      = 6'h0a;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        ck;
    logic        cke;
    logic        cs;
    logic [5:0]  ca;
    logic [15:0] dq;
  } dwt_pins_s;

  typedef struct packed {
    logic [5:0] wl;
    logic [5:0] rl;
  } dwt_lat_s;

  typedef enum logic [3:0] {
    TR_IDLE   = 4'b0001,
    TR_LAT    = 4'b0010,
    TR_WBURST = 4'b0100,
    TR_RBURST = 4'b1000
  } dwt_tr_e;

endpackage

`default_nettype wire

/* design/dwt_sync.sv */
// two-flop synchroniser for a bundle of pin inputs
`default_nettype none

module dwt_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         core_clk_in,
  input  wire logic         rst_in,
  input  wire logic [W-1:0] d_in,
  output var  logic [W-1:0] q_out
);

  logic [W-1:0] meta;

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      meta  <= '0;
      q_out <= '0;
    end else begin
      meta  <= d_in;
      q_out <= meta;
    end
  end

endmodule // dwt_sync

`default_nettype wire

/* design/dwt_top.sv */
// one channel of write-training fifo and dqs interval oscillator
`default_nettype none

module dwt_top (
  input  wire logic        core_clk_in,
  input  wire logic        rst_in,
  input  wire logic        ck_in,
  input  wire logic        cke_in,
  input  wire logic        cs_in,
  input  wire logic [5:0]  ca_in,
  input  wire logic [15:0] dq_in,
  output var  logic [15:0] dq_out,
  output var  logic        dq_oe_out,
  input  wire logic [2:0]  reg_addr_in,
  input  wire logic [15:0] reg_wdata_in,
  input  wire logic        reg_wr_in,
  input  wire logic        reg_rd_in,
  output var  logic [15:0] reg_rdata_out
);

  // ----------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------
  dwt_pkg::dwt_pins_s pins;
  logic [$bits(dwt_pkg::dwt_pins_s)-1:0] pins_raw;
  logic [$bits(dwt_pkg::dwt_pins_s)-1:0] pins_sync;

  assign pins_raw = {ck_in, cke_in, cs_in, ca_in, dq_in};
  assign pins     = pins_sync;

  dwt_sync #(
    .W ($bits(dwt_pkg::dwt_pins_s))
  ) u_sync (
    .core_clk_in (core_clk_in),
    .rst_in      (rst_in),
    .d_in        (pins_raw),
    .q_out       (pins_sync)
  );

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  dwt_pkg::dwt_tr_e state, next_state;
  logic [2:0] wr_ptr, next_wr_ptr;
  logic [2:0] rd_ptr, next_rd_ptr;
  logic [4:0] valid, next_valid;
  logic       ck_prev, next_ck_prev;
  logic       half2, next_half2;
  logic [5:0] first_ca, next_first_ca;
  logic       pend_wr, next_pend_wr;
  logic       pend_rd, next_pend_rd;
  logic       ck_rise, ck_fall, beat_edge;
  logic       cmd_done;
  logic [4:0] cmd_code;
  logic [5:0] mpc_op;
  logic       mpc_train, mpc_nop;
  logic       start_wr, start_rd, disturb;
  logic       osc_start_cmd, osc_stop_cmd;

  assign ck_rise   = pins.ck & ~ck_prev;
  assign ck_fall   = ~pins.ck & ck_prev;
  assign beat_edge = ck_rise | ck_fall;
  assign cmd_done  = ck_rise & half2;
  assign cmd_code  = first_ca[4:0];
  assign mpc_op    = pins.ca;
  assign mpc_nop   = cmd_done && (cmd_code == dwt_pkg::CMD_MPC) && !first_ca[dwt_pkg::OP6_BIT];
  assign mpc_train = cmd_done && (cmd_code == dwt_pkg::CMD_MPC) && first_ca[dwt_pkg::OP6_BIT];
  assign osc_start_cmd = mpc_train && (mpc_op == dwt_pkg::MPC_OSC_START);
  assign osc_stop_cmd  = mpc_train && (mpc_op == dwt_pkg::MPC_OSC_STOP);
  assign start_wr = cmd_done && (cmd_code == dwt_pkg::CMD_CAS2) && pend_wr && (state == dwt_pkg::TR_IDLE);
  assign start_rd = cmd_done && (cmd_code == dwt_pkg::CMD_CAS2) && pend_rd && (state == dwt_pkg::TR_IDLE);
  assign disturb = !pins.cke
                 || (cmd_done && ((cmd_code == dwt_pkg::CMD_WR) || (cmd_code == dwt_pkg::CMD_MWR)
                                  || (cmd_code == dwt_pkg::CMD_RD) || (cmd_code == dwt_pkg::CMD_MRR)))
                 || (mpc_train && (mpc_op == dwt_pkg::MPC_RD_CAL));

  always_comb begin
    next_ck_prev  = pins.ck;
    next_half2    = half2;
    next_first_ca = first_ca;
    next_pend_wr  = pend_wr;
    next_pend_rd  = pend_rd;
    if (ck_rise) begin
      if (half2) begin
        next_half2 = 1'b0;
      end else if (pins.cs && pins.cke) begin
        next_half2    = 1'b1;
        next_first_ca = pins.ca;
      end
    end
    // nop starts nothing but clears pend_wr and pend_rd
    if (cmd_done) begin
      next_pend_wr = mpc_train && (mpc_op == dwt_pkg::MPC_WR_FIFO);
      next_pend_rd = mpc_train && (mpc_op == dwt_pkg::MPC_RD_FIFO);
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      ck_prev  <= 1'b0;
      half2    <= 1'b0;
      first_ca <= 6'h00;
      pend_wr  <= 1'b0;
      pend_rd  <= 1'b0;
    end else begin
      ck_prev  <= next_ck_prev;
      half2    <= next_half2;
      first_ca <= next_first_ca;
      pend_wr  <= next_pend_wr;
      pend_rd  <= next_pend_rd;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic               auto_en, next_auto_en;
  logic [15:0]        runlen, next_runlen;
  dwt_pkg::dwt_lat_s  lat, next_lat;
  logic [15:0]        next_rdata;
  logic               osc_run, osc_short;
  logic [7:0]         osc_lo, osc_hi;

  always_comb begin
    next_auto_en = auto_en;
    next_runlen  = runlen;
    next_lat     = lat;
    next_rdata   = 16'h0000;
    if (reg_wr_in) begin
      case (reg_addr_in)
        dwt_pkg::ADDR_CTRL:   next_auto_en = reg_wdata_in[dwt_pkg::CTRL_AUTO_BIT];
        dwt_pkg::ADDR_RUNLEN: next_runlen  = reg_wdata_in;
        dwt_pkg::ADDR_LAT:    next_lat     = reg_wdata_in[$bits(dwt_pkg::dwt_lat_s)-1:0];
        default:              next_lat     = lat;
      endcase
    end
    if (reg_rd_in) begin
      case (reg_addr_in)
        dwt_pkg::ADDR_OSC_LOW:  next_rdata = {8'h00, osc_lo};
        dwt_pkg::ADDR_OSC_HIGH: next_rdata = {8'h00, osc_hi};
        dwt_pkg::ADDR_CTRL:     next_rdata = {15'h0000, auto_en};
        dwt_pkg::ADDR_RUNLEN:   next_rdata = runlen;
        dwt_pkg::ADDR_LAT:      next_rdata = {4'h0, lat};
        dwt_pkg::ADDR_STATUS:   next_rdata = {2'h0, valid, rd_ptr, wr_ptr, (state != dwt_pkg::TR_IDLE),
                                              osc_short, osc_run};
        default:                next_rdata = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      auto_en       <= 1'b0;
      runlen        <= dwt_pkg::RUNLEN_RESET;
      lat           <= '{wl: dwt_pkg::WL_RESET, rl: dwt_pkg::RL_RESET};
      reg_rdata_out <= 16'h0000;
    end else begin
      auto_en       <= next_auto_en;
      runlen        <= next_runlen;
      lat           <= next_lat;
      reg_rdata_out <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // training fifo
  // ----------------------------------------------------------------
  logic [5:0]  lat_cnt, next_lat_cnt;
  logic [3:0]  beat, next_beat;
  logic [2:0]  cur_entry, next_cur_entry;
  logic        is_wr, next_is_wr;
  logic [15:0] next_dq;
  logic        next_oe;
  logic        mem_we;
  logic [6:0]  mem_idx;
  logic [5:0]  start_lat;
  logic [15:0] mem [0:dwt_pkg::FIFO_WORDS-1];

  assign mem_idx   = {cur_entry, beat};
  assign start_lat = start_wr ? lat.wl : lat.rl;

  always_comb begin
    next_state     = state;
    next_lat_cnt   = lat_cnt;
    next_beat      = beat;
    next_cur_entry = cur_entry;
    next_wr_ptr    = wr_ptr;
    next_rd_ptr    = rd_ptr;
    // disturb clears, a finishing burst still sets
    next_valid     = disturb ? 5'h00 : valid;
    next_is_wr     = is_wr;
    next_dq        = dq_out;
    next_oe        = dq_oe_out;
    mem_we         = 1'b0;
    unique case (state)
      dwt_pkg::TR_IDLE: begin
        if (beat_edge) next_oe = 1'b0;
        if (start_wr || start_rd) begin
          next_is_wr     = start_wr;
          next_cur_entry = start_wr ? wr_ptr : rd_ptr;
          next_beat      = dwt_pkg::BEAT_FIRST;
          next_lat_cnt   = start_lat;
          if (start_lat == 6'h00) next_state = start_wr ? dwt_pkg::TR_WBURST : dwt_pkg::TR_RBURST;
          else next_state = dwt_pkg::TR_LAT;
        end
      end
      dwt_pkg::TR_LAT: begin
        if (ck_rise) begin
          next_lat_cnt = lat_cnt - 6'h01;
          if (lat_cnt == 6'h01) next_state = is_wr ? dwt_pkg::TR_WBURST : dwt_pkg::TR_RBURST;
        end
      end
      dwt_pkg::TR_WBURST: begin
        if (beat_edge) begin
          mem_we    = 1'b1;
          next_beat = beat + 4'h1;
          if (beat == dwt_pkg::BEAT_LAST) begin
            next_state            = dwt_pkg::TR_IDLE;
            next_valid[cur_entry] = 1'b1;
            next_wr_ptr = (wr_ptr == dwt_pkg::ENTRY_LAST) ? dwt_pkg::ENTRY_FIRST : wr_ptr + 3'h1;
          end
        end
      end
      dwt_pkg::TR_RBURST: begin
        if (beat_edge) begin
          next_dq   = valid[cur_entry] ? mem[mem_idx] : dwt_pkg::UNDEF_FILL;
          next_oe   = 1'b1;
          next_beat = beat + 4'h1;
          if (beat == dwt_pkg::BEAT_LAST) begin
            next_state = dwt_pkg::TR_IDLE;
            next_rd_ptr = (rd_ptr == dwt_pkg::ENTRY_LAST) ? dwt_pkg::ENTRY_FIRST : rd_ptr + 3'h1;
          end
        end
      end
    endcase
  end

  always_ff @(posedge core_clk_in) begin
    if (mem_we) mem[mem_idx] <= pins.dq;
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      state     <= dwt_pkg::TR_IDLE;
      lat_cnt   <= 6'h00;
      beat      <= dwt_pkg::BEAT_FIRST;
      cur_entry <= dwt_pkg::ENTRY_FIRST;
      wr_ptr    <= dwt_pkg::ENTRY_FIRST;
      rd_ptr    <= dwt_pkg::ENTRY_FIRST;
      valid     <= 5'h00;
      is_wr     <= 1'b0;
      dq_out    <= 16'h0000;
      dq_oe_out <= 1'b0;
    end else begin
      state     <= next_state;
      lat_cnt   <= next_lat_cnt;
      beat      <= next_beat;
      cur_entry <= next_cur_entry;
      wr_ptr    <= next_wr_ptr;
      rd_ptr    <= next_rd_ptr;
      valid     <= next_valid;
      is_wr     <= next_is_wr;
      dq_out    <= next_dq;
      dq_oe_out <= next_oe;
    end
  end

  // ----------------------------------------------------------------
  // dqs interval oscillator
  // ----------------------------------------------------------------
  // this channel's own oscillator state
  logic        next_run, next_short, osc_stop;
  logic [15:0] osc_cnt, next_cnt, auto_cnt, next_auto, auto_inc;
  logic [7:0]  next_lo, next_hi;

  assign auto_inc = 16'(auto_cnt + 16'h0001);
  // auto stop, stop command ignored in auto mode
  assign osc_stop = osc_run && (auto_en ? (ck_rise && (auto_inc >= runlen)) : osc_stop_cmd);

  always_comb begin
    next_run   = osc_run;
    next_cnt   = osc_cnt;
    next_auto  = auto_cnt;
    next_lo    = osc_lo;
    next_hi    = osc_hi;
    next_short = osc_short;
    if (osc_run) begin
      if (osc_cnt != dwt_pkg::OSC_MAX) next_cnt = osc_cnt + 16'h0001;
      if (ck_rise) next_auto = auto_inc;
    end
    if (osc_stop) begin
      next_run   = 1'b0;
      next_lo    = osc_cnt[7:0];
      next_hi    = osc_cnt[15:8];
      next_short = osc_cnt < dwt_pkg::OSC_MIN_RUN_CYC;
    end
    if (osc_start_cmd) begin
      next_run  = 1'b1;
      next_cnt  = 16'h0000;
      next_auto = 16'h0000;
    end
  end

  always_ff @(posedge core_clk_in or posedge rst_in) begin
    if (rst_in) begin
      osc_run   <= 1'b0;
      osc_cnt   <= 16'h0000;
      auto_cnt  <= 16'h0000;
      osc_lo    <= 8'h00;
      osc_hi    <= 8'h00;
      osc_short <= 1'b0;
    end else begin
      osc_run   <= next_run;
      osc_cnt   <= next_cnt;
      auto_cnt  <= next_auto;
      osc_lo    <= next_lo;
      osc_hi    <= next_hi;
      osc_short <= next_short;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  AST_OP6_NOP: assert property (mpc_nop |=> (state == $past(state)) && (osc_run == $past(osc_run)))
    else $error("nop command changed training state");
  AST_RESERVED_IGNORED: assert property (mpc_train && (mpc_op != dwt_pkg::MPC_OSC_START) && !osc_stop
                                         && (state == dwt_pkg::TR_IDLE) |=> (state == dwt_pkg::TR_IDLE)
                                         && (osc_run == $past(osc_run)))
    else $error("training command started a burst without cas-2");
  AST_WR_LATENCY: assert property (start_wr && (lat.wl != 6'h00) |=> (state == dwt_pkg::TR_LAT)
                                   && (lat_cnt == $past(lat.wl)) && is_wr)
    else $error("write fifo latency not loaded");
  AST_RD_LATENCY: assert property (start_rd && (lat.rl != 6'h00) |=> (state == dwt_pkg::TR_LAT)
                                   && (lat_cnt == $past(lat.rl)) && !is_wr)
    else $error("read fifo latency not loaded");
  AST_WR_PTR_WRAP: assert property ((state == dwt_pkg::TR_WBURST) && beat_edge && (beat == dwt_pkg::BEAT_LAST)
                                    |=> (wr_ptr == (($past(wr_ptr) == dwt_pkg::ENTRY_LAST) ? dwt_pkg::ENTRY_FIRST
                                                    : $past(wr_ptr) + 3'h1)))
    else $error("write pointer did not step or wrap");
  AST_RD_PTR_WRAP: assert property ((state == dwt_pkg::TR_RBURST) && beat_edge && (beat == dwt_pkg::BEAT_LAST)
                                    |=> (rd_ptr == (($past(rd_ptr) == dwt_pkg::ENTRY_LAST) ? dwt_pkg::ENTRY_FIRST
                                                    : $past(rd_ptr) + 3'h1)))
    else $error("read pointer did not step or wrap");
  AST_RD_KEEPS: assert property ((state == dwt_pkg::TR_RBURST) && !disturb |=> (wr_ptr == $past(wr_ptr))
                                 && (valid == $past(valid)))
    else $error("fifo read altered contents");
  AST_DISTURB: assert property (disturb && !(mem_we && (beat == dwt_pkg::BEAT_LAST)) |=> (valid == 5'h00))
    else $error("disturbing command left entries valid");
  AST_UNDEF_FILL: assert property ((state == dwt_pkg::TR_RBURST) && beat_edge && !valid[cur_entry]
                                   |=> dq_oe_out && (dq_out == dwt_pkg::UNDEF_FILL))
    else $error("unwritten entry not filler");
  AST_OSC_START: assert property (osc_start_cmd |=> osc_run ##1 (osc_cnt == 16'h0001))
    else $error("oscillator did not start");
  AST_AUTO_STOP: assert property (osc_run && auto_en && ck_rise && (auto_inc >= runlen) && !osc_start_cmd
                                  |=> !osc_run)
    else $error("oscillator did not auto stop");
  AST_STORE: assert property (osc_stop && !osc_start_cmd |=> ({osc_hi, osc_lo} == $past(osc_cnt)))
    else $error("stored count mismatch");
  AST_SATURATE: assert property (osc_run && (osc_cnt == dwt_pkg::OSC_MAX) && !osc_start_cmd
                                 |=> (osc_cnt == dwt_pkg::OSC_MAX))
    else $error("oscillator count wrapped");

  COV_WR_BURST: cover property ((state == dwt_pkg::TR_WBURST) ##1 (state == dwt_pkg::TR_IDLE));
  COV_RD_BURST: cover property ((state == dwt_pkg::TR_RBURST) ##1 (state == dwt_pkg::TR_IDLE));
  COV_AUTO_STOP: cover property (osc_stop && auto_en);
  COV_RD_WRAP: cover property ((rd_ptr == dwt_pkg::ENTRY_LAST) ##[1:1000] (rd_ptr == dwt_pkg::ENTRY_FIRST));

endmodule // dwt_top

`default_nettype wire

/* bench/dwt_ctl_model.sv */
// controller-side link model for the training block
`default_nettype none

module dwt_ctl_model (
  input  wire logic        core_clk_in,
  input  wire logic [15:0] dq_in,
  input  wire logic        oe_in,
  output var  logic        ck_out,
  output var  logic        cke_out,
  output var  logic        cs_out,
  output var  logic [5:0]  ca_out,
  output var  logic [15:0] dq_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    ck_out = 1'b0;
    cke_out = 1'b1;
    cs_out = 1'b0;
    ca_out = 6'h00;
    dq_out = 16'h0000;
  end
  // ----------------------------------------
  // one ck half, samples the device reply
  // ----------------------------------------
  task automatic half(input logic c, input logic s, input logic [5:0] a, input logic [15:0] d,
                      output logic [16:0] q);
    @(posedge core_clk_in);
    q = {oe_in, dq_in};
    ck_out <= c;
    cs_out <= s;
    ca_out <= a;
    dq_out <= d;
    repeat (3) @(posedge core_clk_in);
  endtask
  task automatic cmd(input logic [5:0] a1, input logic [5:0] a2, input logic [15:0] d,
                     output logic [16:0] q);
    half(1'b1, 1'b1, a1, ~d, q);
    half(1'b0, 1'b1, a1, ~d, q);
    half(1'b1, 1'b0, a2, ~d, q);
    half(1'b0, 1'b0, a2, d, q);
  endtask
  task automatic cke_low();
    @(posedge core_clk_in);
    cke_out <= 1'b0;
    repeat (4) @(posedge core_clk_in);
    cke_out <= 1'b1;
  endtask
endmodule // dwt_ctl_model

`default_nettype wire

/* bench/tb_top.sv */
// self-checking bench for the training fifo and oscillator
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [6:0] WRF = {1'b1, dwt_pkg::MPC_WR_FIFO};
  localparam logic [6:0] RDF = {1'b1, dwt_pkg::MPC_RD_FIFO};
  localparam logic [5:0] MPC = {1'b1, dwt_pkg::CMD_MPC};
  logic        clk;
  logic        rst;
  logic        ck;
  logic        cke;
  logic        cs;
  logic [5:0]  ca;
  logic [15:0] dq_i;
  logic [15:0] dq_o;
  logic        oe;
  logic [2:0]  addr;
  logic [15:0] wdata;
  logic [15:0] rdata;
  logic        wr;
  logic        rd;
  logic [16:0] q;
  logic [15:0] ev;
  int          lat_n = 0;
  int          error_cnt = 0;
  int          checked = 0;
  dwt_top u_dut (.core_clk_in(clk), .rst_in(rst), .ck_in(ck), .cke_in(cke), .cs_in(cs), .ca_in(ca),
    .dq_in(dq_i), .dq_out(dq_o), .dq_oe_out(oe), .reg_addr_in(addr), .reg_wdata_in(wdata),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata));
  dwt_ctl_model u_ctl (.core_clk_in(clk), .dq_in(dq_o), .oe_in(oe), .ck_out(ck), .cke_out(cke),
    .cs_out(cs), .ca_out(ca), .dq_out(dq_i));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  task automatic chk(input logic [16:0] got, input logic [16:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic reg_wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task automatic rchk(input logic [2:0] a, input logic [15:0] m, input logic [15:0] e);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    @(posedge clk);
    chk({1'b0, rdata & m}, {1'b0, e});
  endtask
  task automatic fifo_op(input logic [6:0] op, input logic [7:0] seed, input logic [7:0] es);
    u_ctl.cmd({op[6], dwt_pkg::CMD_MPC}, op[5:0], 16'h0, q);
    u_ctl.cmd({1'b0, dwt_pkg::CMD_CAS2}, 6'h00, {seed, 8'h00}, q);
    // beat b stands in half 2 * lat_n + b, ck ends low
    for (int i = 1; i < 19 + 2 * lat_n; i++) begin
      u_ctl.half(i[0], 1'b0, 6'h00, {seed, 8'(i - 2 * lat_n)}, q);
      ev = (es == 8'h00) ? dwt_pkg::UNDEF_FILL : {es, 8'(i - 1 - 2 * lat_n)};
      if (op == RDF && i > 2 * lat_n && i < 17 + 2 * lat_n) chk(q, {1'b1, ev});
      if (op == RDF && i == 17 + 2 * lat_n) chk({16'h0, q[16]}, 17'h0);
    end
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs();
    logic [15:0] rv [8];
    rv = '{16'h0, 16'h0, 16'h0, dwt_pkg::RUNLEN_RESET, {4'h0, dwt_pkg::WL_RESET, dwt_pkg::RL_RESET},
           16'h0, 16'h0, 16'h0};
    for (int a = 0; a < 8; a++) rchk(3'(a), 16'hffff, rv[a]);
    reg_wr(dwt_pkg::ADDR_OSC_LOW, 16'h00a5);
    rchk(dwt_pkg::ADDR_OSC_LOW, 16'hffff, 16'h0000);
    reg_wr(dwt_pkg::ADDR_LAT, 16'h0000);
    rchk(dwt_pkg::ADDR_LAT, 16'hffff, 16'h0000);
  endtask
  task automatic t_fifo();
    logic [7:0] want [11];
    want = '{8'h1, 8'h2, 8'h3, 8'h0, 8'h0, 8'h1, 8'h2, 8'h3, 8'h4, 8'h5, 8'h6};
    for (int s = 1; s < 4; s++) fifo_op(WRF, 8'(s), 8'h0);
    for (int r = 0; r < 6; r++) fifo_op(RDF, 8'hc3, want[r]);
    for (int s = 4; s < 7; s++) fifo_op(WRF, 8'(s), 8'h0);
    for (int r = 6; r < 11; r++) fifo_op(RDF, 8'h3c, want[r]);
    rchk(dwt_pkg::ADDR_STATUS, 16'hffff, {2'b00, 5'h1f, 3'h1, 3'h1, 3'h0});
  endtask
  task automatic t_disturb();
    reg_wr(dwt_pkg::ADDR_LAT, 16'h0041);
    lat_n = 1;
    fifo_op({1'b0, dwt_pkg::MPC_WR_FIFO}, 8'h99, 8'h0);
    fifo_op(RDF, 8'hc3, 8'h2);
    u_ctl.cmd({1'b0, dwt_pkg::CMD_RD}, 6'h00, 16'h0, q);
    rchk(dwt_pkg::ADDR_STATUS, 16'hffff, {2'b00, 5'h00, 3'h2, 3'h1, 3'h0});
    fifo_op(WRF, 8'h55, 8'h0);
    fifo_op(RDF, 8'hc3, 8'h0);
    rchk(dwt_pkg::ADDR_STATUS, 16'hffff, {2'b00, 5'h02, 3'h3, 3'h2, 3'h0});
    u_ctl.cke_low();
    rchk(dwt_pkg::ADDR_STATUS, 16'hffff, {2'b00, 5'h00, 3'h3, 3'h2, 3'h0});
  endtask
  task automatic osc_run(input int w);
    u_ctl.cmd(MPC, dwt_pkg::MPC_OSC_START, 16'h0, q);
    rchk(dwt_pkg::ADDR_STATUS, 16'h0001, 16'h0001);
    repeat (w - 3) @(posedge clk);
    // manual stop, run over 200 ns
    u_ctl.cmd(MPC, dwt_pkg::MPC_OSC_STOP, 16'h0, q);
    // the two second rises are w + 16 cycles apart, count starts at zero
    ev = (w + 15 > 65535) ? dwt_pkg::OSC_MAX : 16'(w + 15);
    rchk(dwt_pkg::ADDR_OSC_LOW, 16'hffff, {8'h00, ev[7:0]});
    rchk(dwt_pkg::ADDR_OSC_HIGH, 16'hffff, {8'h00, ev[15:8]});
  endtask
  task automatic t_auto();
    reg_wr(dwt_pkg::ADDR_CTRL, 16'h0001);
    reg_wr(dwt_pkg::ADDR_RUNLEN, 16'h0004);
    u_ctl.cmd(MPC, dwt_pkg::MPC_OSC_START, 16'h0, q);
    for (int i = 1; i < 7; i++) u_ctl.half(i[0], 1'b0, 6'h00, 16'(i), q);
    rchk(dwt_pkg::ADDR_STATUS, 16'h0001, 16'h0001);
    u_ctl.half(1'b1, 1'b0, 6'h00, 16'h0007, q);
    u_ctl.half(1'b0, 1'b0, 6'h00, 16'h0008, q);
    rchk(dwt_pkg::ADDR_STATUS, 16'h0001, 16'h0000);
    // fourth rise lands 35 core cycles after the start rise
    rchk(dwt_pkg::ADDR_OSC_LOW, 16'hffff, 16'h0022);
  endtask
  initial begin
    rst = 1'b1;
    addr = 3'h0;
    wdata = 16'h0000;
    wr = 1'b0;
    rd = 1'b0;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_fifo();
    t_disturb();
    osc_run(300);
    osc_run(65600);
    t_auto();
    end_sim();
  end
  initial begin
    #4000000;
    error_cnt++;
    end_sim();
  end
endmodule // tb_top

`default_nettype wire
